// ==== hdl/tlirq_pkg.sv ====
`default_nettype none
package tlirq_pkg;
    // Register byte addresses (all printed offsets are word aligned)
    localparam logic [31:0] MISSED_IRQ_FLAGS_ADDR  = 32'h4000_a820;
    localparam logic [31:0] IRQ_ENABLE_SET_ADDR    = 32'he000_e100;
    localparam logic [31:0] IRQ_ENABLE_CLEAR_ADDR  = 32'he000_e180;
    localparam logic [31:0] IRQ_PEND_SET_ADDR      = 32'he000_e200;
    localparam logic [31:0] IRQ_PEND_CLEAR_ADDR    = 32'he000_e280;
    localparam logic [31:0] IRQ_ACTIVE_STATUS_ADDR = 32'he000_e300;
    localparam logic [31:0] AUX_FAULT_STATUS_ADDR  = 32'he000_ed3c;
    // Implemented source bits: 16,15,14,12,10,9,8,7,5,4,3,2
    localparam logic [31:0] SRC_MASK               = 32'h0001_d7bc;
    // Missed flags exist for every source but the debug one
    localparam logic [31:0] MISS_MASK              = 32'h0000_d7bc;
    // Fault status field positions
    localparam int          FLT_BAD_WIDTH          = 3;
    localparam int          FLT_PROTECTED          = 2;
    localparam int          FLT_UNMAPPED           = 1;
    localparam int          FLT_REPEAT             = 0;
    localparam logic [31:0] FLT_MASK               = 32'h0000_000f;
    // Reset value shared by every register
    localparam logic [31:0] REG_RESET              = 32'h0000_0000;
    // AXI responses
    localparam logic [1:0]  RESP_OKAY              = 2'b00;
    localparam logic [1:0]  RESP_SLVERR            = 2'b10;
endpackage
`default_nettype wire

// ==== hdl/tlirq_axil.sv ====
`default_nettype none
// AXI4-Lite slave front end: accepts one write and one read at a time
module tlirq_axil (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Write address, data and response
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // Read channels
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Register side
    output logic             wr_stb,
    output logic [31:0]      wr_addr,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    input  wire logic        wr_hit,
    output logic             rd_stb,
    output logic [31:0]      rd_addr,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_hit
);
    logic have_aw;
    logic have_w;

    ////////////////////////////////////////////////////////////////////////////////
    // Write path: hold address and data until both are in, then strobe once
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            have_aw       <= 1'b0;
            have_w        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            wr_stb        <= 1'b0;
            wr_addr       <= 32'h0000_0000;
            wr_data       <= 32'h0000_0000;
            wr_strb       <= 4'h0;
        end else begin
            wr_stb        <= 1'b0;
            s_axi_awready <= !have_aw && !s_axi_awready && !s_axi_bvalid && !wr_stb;
            s_axi_wready  <= !have_w && !s_axi_wready && !s_axi_bvalid && !wr_stb;
            if (s_axi_awvalid && s_axi_awready) begin
                have_aw <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                have_w  <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (have_aw && have_w) begin
                have_aw <= 1'b0;
                have_w  <= 1'b0;
                wr_stb  <= 1'b1;
            end
            // Response one cycle after the strobe, once decode is known
            if (wr_stb) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? tlirq_pkg::RESP_OKAY : tlirq_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path: capture address, answer the next cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'b00;
            rd_stb        <= 1'b0;
            rd_addr       <= 32'h0000_0000;
        end else begin
            rd_stb        <= 1'b0;
            s_axi_arready <= !s_axi_arready && !rd_stb && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                rd_addr <= s_axi_araddr;
                rd_stb  <= 1'b1;
            end
            if (rd_stb) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_data;
                s_axi_rresp  <= rd_hit ? tlirq_pkg::RESP_OKAY : tlirq_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== hdl/tlirq_top.sv ====
// Added by the designer: the AXI4-Lite interface to the registers.
`default_nettype none
module tlirq_top (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // AXI4-Lite write channels
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Peripheral interrupt events, one-cycle pulses at the source bit positions
    input  wire logic [31:0] src_event,
    // Core handshake: entry and exit of service per source, one-cycle pulses
    input  wire logic [31:0] svc_enter,
    input  wire logic [31:0] svc_exit,
    // Bus fault reports from the system bus, one-cycle pulses
    input  wire logic        flt_valid,
    input  wire logic        flt_narrow_periph,
    input  wire logic        flt_unaligned_word,
    input  wire logic        flt_user_protected_wr,
    input  wire logic        flt_above_last_reg,
    input  wire logic        flt_above_mem_end,
    // Interrupt requests to the core and the bus fault pulse
    output logic [31:0]      irq_req,
    output logic             bus_fault
);
    logic        wr_stb;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_hit;
    logic        rd_stb;
    logic [31:0] rd_addr;
    logic [31:0] rd_data;
    logic        rd_hit;
    logic [31:0] wmask;
    logic [31:0] enable_mask;
    logic [31:0] pending;
    logic [31:0] active;
    logic [31:0] missed;
    logic [31:0] fault;
    logic [31:0] new_fault;
    logic [31:0] next_pending;

    // Byte lanes expanded to a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    // Write strobe aimed at one register
    function automatic logic hit_wr(input logic [31:0] a);
        return wr_stb && (wr_addr == a);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave
    tlirq_axil u_axil (
        .clk           (clk),
        .rst           (rst),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_stb        (wr_stb),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_hit        (wr_hit),
        .rd_stb        (rd_stb),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_hit        (rd_hit)
    );

    // Effective write bits: only ones on enabled lanes count
    assign wmask = wr_data & lane_mask(wr_strb);

    // Write decode; active register is not writable
    always_comb begin
        unique case (wr_addr)
            tlirq_pkg::MISSED_IRQ_FLAGS_ADDR,
            tlirq_pkg::IRQ_ENABLE_SET_ADDR,
            tlirq_pkg::IRQ_ENABLE_CLEAR_ADDR,
            tlirq_pkg::IRQ_PEND_SET_ADDR,
            tlirq_pkg::IRQ_PEND_CLEAR_ADDR,
            tlirq_pkg::AUX_FAULT_STATUS_ADDR: wr_hit = 1'b1;
            default:                          wr_hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Enable masks; set and clear in one write cannot happen (separate addresses)
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enable_mask <= tlirq_pkg::REG_RESET;
        end else if (hit_wr(tlirq_pkg::IRQ_ENABLE_SET_ADDR)) begin
            enable_mask <= enable_mask | (wmask & tlirq_pkg::SRC_MASK);
        end else if (hit_wr(tlirq_pkg::IRQ_ENABLE_CLEAR_ADDR)) begin
            enable_mask <= enable_mask & ~(wmask & tlirq_pkg::SRC_MASK);
        end
    end

    // Pending latch: events and software set, pend-clear and service entry clear.
    // A set in the same cycle as a clear wins, so no event is dropped.
    always_comb begin
        next_pending = pending;
        if (hit_wr(tlirq_pkg::IRQ_PEND_CLEAR_ADDR)) begin
            next_pending = next_pending & ~wmask;
        end
        next_pending = next_pending & ~svc_enter;
        if (hit_wr(tlirq_pkg::IRQ_PEND_SET_ADDR)) begin
            next_pending = next_pending | wmask;
        end
        next_pending = (next_pending | src_event) & tlirq_pkg::SRC_MASK;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pending <= tlirq_pkg::REG_RESET;
        end else begin
            pending <= next_pending;
        end
    end

    // Active status tracks the core's service window
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active <= tlirq_pkg::REG_RESET;
        end else begin
            active <= ((active & ~svc_exit) | svc_enter) & tlirq_pkg::SRC_MASK;
        end
    end

    // Request is level: pending gated by mask, order of setting irrelevant
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_req <= tlirq_pkg::REG_RESET;
        end else begin
            irq_req <= next_pending & enable_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Missed flags: an enabled event hitting a still-pending source is lost
    // because nothing counts or queues. Detection wins over a clear.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            missed <= tlirq_pkg::REG_RESET;
        end else begin
            missed <= ((missed & ~(hit_wr(tlirq_pkg::MISSED_IRQ_FLAGS_ADDR)
                                   ? wmask : 32'h0000_0000))
                       | (src_event & pending & enable_mask))
                      & tlirq_pkg::MISS_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Fault causes of one access, possibly several at once
    always_comb begin
        new_fault = 32'h0000_0000;
        new_fault[tlirq_pkg::FLT_BAD_WIDTH] = flt_narrow_periph
                                            | flt_unaligned_word;
        new_fault[tlirq_pkg::FLT_PROTECTED] = flt_user_protected_wr;
        new_fault[tlirq_pkg::FLT_UNMAPPED]  = flt_above_last_reg
                                            | flt_above_mem_end;
        new_fault[tlirq_pkg::FLT_REPEAT]    = |fault;
        if (!flt_valid) begin
            new_fault = 32'h0000_0000;
        end
    end

    // Sticky fault status; software write of one clears a bit, new fault wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fault <= tlirq_pkg::REG_RESET;
        end else begin
            fault <= ((fault & ~(hit_wr(tlirq_pkg::AUX_FAULT_STATUS_ADDR)
                                 ? wmask : 32'h0000_0000))
                      | new_fault) & tlirq_pkg::FLT_MASK;
        end
    end

    // Fault pulse to the core, one cycle after the report
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_fault <= 1'b0;
        end else begin
            bus_fault <= flt_valid && (|new_fault[3:1]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux; set/clear addresses read back the state they steer
    always_comb begin
        rd_hit = 1'b1;
        unique case (rd_addr)
            tlirq_pkg::IRQ_ENABLE_SET_ADDR,
            tlirq_pkg::IRQ_ENABLE_CLEAR_ADDR:  rd_data = enable_mask;
            tlirq_pkg::IRQ_PEND_SET_ADDR,
            tlirq_pkg::IRQ_PEND_CLEAR_ADDR:    rd_data = pending;
            tlirq_pkg::IRQ_ACTIVE_STATUS_ADDR: rd_data = active;
            tlirq_pkg::MISSED_IRQ_FLAGS_ADDR:  rd_data = missed;
            tlirq_pkg::AUX_FAULT_STATUS_ADDR:  rd_data = fault;
            default: begin
                rd_data = 32'h0000_0000;
                rd_hit  = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

// ==== testbench/tlirq_monitor.sv ====
`default_nettype none
// Port-level watcher for the interrupt and fault register block
module tlirq_monitor (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Bus handshakes
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // Events, core handshake and fault reports
    input wire logic [31:0] src_event,
    input wire logic [31:0] svc_enter,
    input wire logic        flt_valid,
    input wire logic        flt_narrow_periph,
    input wire logic        flt_unaligned_word,
    input wire logic        flt_user_protected_wr,
    input wire logic        flt_above_last_reg,
    input wire logic        flt_above_mem_end,
    // Outputs under watch
    input wire logic [31:0] irq_req,
    input wire logic        bus_fault
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic any_cause;
    // Causes that land in the status bits above the repeat flag
    assign any_cause = flt_narrow_periph | flt_unaligned_word | flt_user_protected_wr
        | flt_above_last_reg | flt_above_mem_end;
    ////////////////////////////////////////////////////////////
    chk_reset_quiet: assert property ($fell(rst) |-> irq_req == 32'h0 && !bus_fault)
        else $error("outputs not quiet after reset");
    chk_fault_sets: assert property (flt_valid && any_cause |=> bus_fault)
        else $error("fault report gave no bus fault pulse");
    chk_fault_quiet: assert property (!flt_valid |=> !bus_fault)
        else $error("bus fault pulse without a report");
    // Requests rise only from an event or a finished register write
    chk_irq_rise: assert property ((irq_req & ~$past(irq_req)) != 32'h0 |->
        ($past(src_event) != 32'h0 || s_axi_bvalid || $past(s_axi_bvalid)))
        else $error("request rose without cause");
    // Level requests stay up until serviced or cleared by software
    chk_irq_level: assert property (($past(irq_req) & ~irq_req) != 32'h0 |->
        ($past(svc_enter) != 32'h0 || s_axi_bvalid || $past(s_axi_bvalid)))
        else $error("request dropped without cause");
    chk_irq_range: assert property ((irq_req & ~tlirq_pkg::SRC_MASK) == 32'h0)
        else $error("request on an unused bit");
    chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
        else $error("read answer late");
    chk_rd_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer not retired");
    chk_wr_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer not retired");
    cover property (flt_valid && flt_above_mem_end);
    cover property ($rose(irq_req[3]));
    cover property (svc_enter != 32'h0);
endmodule
bind tlirq_top tlirq_monitor mon_u (.*);
`default_nettype wire

// ==== testbench/tlirq_core_model.sv ====
`default_nettype none
// Core model: enters and leaves service when the bench commands it
module tlirq_core_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Requests from the block, commands from the bench
    input  wire logic [31:0] irq_req,
    input  wire logic [31:0] take,
    input  wire logic [31:0] done,
    // Service handshake towards the block
    output logic [31:0]      svc_enter,
    output logic [31:0]      svc_exit
);
    timeunit 1ns;
    timeprecision 1ps;
    // A core only enters service of a request it sees, hence the gate
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            svc_enter <= 32'h0;
            svc_exit  <= 32'h0;
        end else begin
            svc_enter <= take & irq_req;
            svc_exit  <= done;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // Addresses and shorthand values
    localparam logic [31:0] EN_S = tlirq_pkg::IRQ_ENABLE_SET_ADDR;
    localparam logic [31:0] EN_C = tlirq_pkg::IRQ_ENABLE_CLEAR_ADDR;
    localparam logic [31:0] PD_S = tlirq_pkg::IRQ_PEND_SET_ADDR;
    localparam logic [31:0] PD_C = tlirq_pkg::IRQ_PEND_CLEAR_ADDR;
    localparam logic [31:0] ACT  = tlirq_pkg::IRQ_ACTIVE_STATUS_ADDR;
    localparam logic [31:0] MIS  = tlirq_pkg::MISSED_IRQ_FLAGS_ADDR;
    localparam logic [31:0] FLT  = tlirq_pkg::AUX_FAULT_STATUS_ADDR;
    localparam logic [31:0] Z    = tlirq_pkg::REG_RESET;
    localparam logic [31:0] ALL  = 32'hffff_ffff;
    localparam logic [1:0]  OK   = tlirq_pkg::RESP_OKAY;
    localparam logic [1:0]  ERR  = tlirq_pkg::RESP_SLVERR;
    localparam int          WAIT = 40;
    localparam logic [31:0] REGS [7] = '{EN_S, EN_C, PD_S, PD_C, ACT, MIS, FLT};
    typedef struct packed {
        logic        wr;
        logic [31:0] addr;
        logic [31:0] data;
        logic [31:0] rd;
        logic [1:0]  resp;
        logic [31:0] irq;
    } tlirq_row_t;
    // Access, address, write data, read data, response, requests afterwards
    localparam tlirq_row_t ROWS [15] = '{
        '{1'b1, EN_S, ALL, Z, OK, Z}, '{1'b0, EN_S, Z, tlirq_pkg::SRC_MASK, OK, Z},
        '{1'b1, EN_C, 32'h4, Z, OK, Z}, '{1'b1, EN_C, Z, Z, OK, Z},
        '{1'b0, EN_C, Z, 32'h0001_d7b8, OK, Z}, '{1'b1, PD_S, 32'h14, Z, OK, 32'h10},
        '{1'b1, PD_S, Z, Z, OK, 32'h10}, '{1'b0, PD_S, Z, 32'h14, OK, 32'h10},
        '{1'b1, EN_S, 32'h4, Z, OK, 32'h14}, '{1'b1, PD_C, 32'h10, Z, OK, 32'h4},
        '{1'b0, PD_C, Z, 32'h4, OK, 32'h4}, '{1'b1, ACT, ALL, Z, ERR, 32'h4},
        '{1'b0, ACT, Z, Z, OK, 32'h4}, '{1'b0, 32'he000_e104, Z, Z, ERR, 32'h4},
        '{1'b1, PD_C, ALL, Z, OK, Z}};
    logic        clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, flt_valid, bus_fault;
    logic        flt_narrow_periph, flt_unaligned_word, flt_user_protected_wr;
    logic        flt_above_last_reg, flt_above_mem_end;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [3:0]  s_axi_wstrb;
    logic [4:0]  cause;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
    logic [31:0] src_event, svc_enter, svc_exit, irq_req, take, done;
    int          fails, n_tests;
    // Fault causes travel as one vector in the bench
    assign {flt_narrow_periph, flt_unaligned_word, flt_user_protected_wr, flt_above_last_reg,
        flt_above_mem_end} = cause;
    tlirq_top dut_u (.*);
    tlirq_core_model core_u (.*);
    ////////////////////////////////////////////////////////////
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (fails == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // A hung handshake counts against the run and ends it
    task automatic give_up();
        fails++;
        tally_and_finish();
    endtask
    // Write: both channels offered at once, each dropped when taken
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
        int k;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (k = 0; k < WAIT; k++) begin
            @(posedge clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        if (k == WAIT) give_up();
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask
    // Read, then compare the word; the extra edge keeps strobes apart
    task automatic read_chk(input logic [31:0] a, input logic [31:0] exp);
        int k;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (k = 0; k < WAIT; k++) begin
            @(posedge clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        if (k == WAIT) give_up();
        rd   = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk);
        check_word(rd, exp);
    endtask
    // One-cycle pulse on events, service entry and service exit
    task automatic kick(input logic [31:0] ev, input logic [31:0] tk, input logic [31:0] dn);
        {src_event, take, done} <= {ev, tk, dn};
        @(posedge clk);
        {src_event, take, done} <= {3{Z}};
        @(posedge clk);
    endtask
    // One fault report, then its pulse and the status word
    task automatic fault_chk(input logic [4:0] c, input logic [31:0] exp);
        {flt_valid, cause} <= {1'b1, c};
        @(posedge clk);
        {flt_valid, cause} <= 6'h00;
        @(posedge clk);
        check_word({31'h0, bus_fault}, 32'h1);
        read_chk(FLT, exp);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Main sequence: reset, table of ordinary accesses, awkward cases
    initial begin
        rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, src_event, take, done} = {6{Z}};
        {flt_valid, cause, s_axi_wstrb} = 10'h00f;
        {fails, n_tests} = {2{32'sd0}};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (REGS[j]) read_chk(REGS[j], Z);
        foreach (ROWS[j]) begin
            if (ROWS[j].wr) axi_write(ROWS[j].addr, ROWS[j].data);
            else read_chk(ROWS[j].addr, ROWS[j].rd);
            check_word({30'h0, resp}, {30'h0, ROWS[j].resp});
            @(posedge clk);
            check_word(irq_req, ROWS[j].irq);
        end
        // Second event while still pending is lost and flagged
        axi_write(EN_S, 32'h0000_2008);
        kick(32'h0000_2008, Z, Z);
        check_word(irq_req, 32'h8);
        kick(32'h8, Z, Z);
        read_chk(MIS, 32'h8);
        axi_write(MIS, 32'h4);
        read_chk(MIS, 32'h8);
        axi_write(MIS, 32'h8);
        read_chk(MIS, Z);
        // Core takes the request: pending drops, active shows it
        kick(Z, 32'h8, Z);
        read_chk(ACT, 32'h8);
        check_word(irq_req, Z);
        kick(Z, Z, 32'h8);
        read_chk(ACT, Z);
        // Several causes at once, repeats, clearing only written ones
        fault_chk(5'h12, 32'ha);
        fault_chk(5'h08, 32'hb);
        axi_write(FLT, 32'h2);
        read_chk(FLT, 32'h9);
        axi_write(FLT, 32'hf);
        fault_chk(5'h04, 32'h4);
        fault_chk(5'h01, 32'h7);
        // Bit 16 has no missed flag; lanes left out of the strobe are not written
        kick(32'h0001_0000, Z, Z);
        kick(32'h0001_0000, Z, Z);
        read_chk(MIS, Z);
        s_axi_wstrb <= 4'h1;
        axi_write(PD_C, ALL);
        read_chk(PD_S, 32'h0001_0000);
        s_axi_wstrb <= 4'hf;
        axi_write(PD_C, ALL);
        read_chk(PD_S, Z);
        // Reset in mid-run clears what software had set
        axi_write(EN_S, ALL);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        read_chk(EN_S, Z);
        read_chk(FLT, Z);
        tally_and_finish();
    end
endmodule
`default_nettype wire
